/* File: hw/interp_dpll_control.v */
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dpll_defs.vh"
// Notes on behaviour
// - loop reset clears detector, filter and step, but not the software registers
// - first error and first step are zero
// - hold freezes integrator and filter word
// - detector keeps running during hold
// - after hold, filter resumes from held state
// - offset select replaces filter word
// - detector and integrator run during override
// - override off gives computed filter word
// - locked error samples average to zero
// - error 21-bit signed, filter 22-bit signed
// - offset value 22-bit signed like filter
// - loop ports synchronous to user clock
// - five-bit step word to interpolator
module interp_dpll_control (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        clk_en,
  input  wire        loop_reset,
  input  wire        ref_in,
  input  wire        hold,
  input  wire        offset_sel,
  input  wire [21:0] offset_value,
  output reg  [4:0]  phase_step_out,
  output reg  [20:0] phase_error_q,
  output reg  [21:0] filter_word_q,
  output reg         update_strobe_q,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  // software registers
  reg  [31:0] gain_q;
  reg  [15:0] ref_div_q;
  reg  [15:0] loc_div_q;
  reg  [15:0] dsp_rate_q;
  // loop state
  reg  [15:0] dsp_cnt_q;
  reg         first_q;
  reg  signed [47:0] integ_q;
  reg  [21:0] calc_q;
  reg  [23:0] sd_acc_q;
  reg         ovf_int_q;
  reg         ovf_filt_q;
  wire [20:0] pd_count;
  wire        pd_ovf;
  wire        dsp_tick = (dsp_cnt_q == dsp_rate_q);
  wire [4:0]  g1   = gain_q[`GAIN_G1_LSB +: 5];
  wire [4:0]  g2   = gain_q[`GAIN_G2_LSB +: 5];
  wire [3:0]  step = gain_q[`GAIN_STEP_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////////////////
  // phase detector, cleared by loop reset and restarted at each update
  phase_compare u_pd (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clk_en  (clk_en),
    .clr     (loop_reset),
    .ref_in  (ref_in),
    .ref_div (ref_div_q),
    .loc_div (loc_div_q),
    .sample  (dsp_tick),
    .count_q (pd_count),
    .ovf_q   (pd_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////////////////
  // filter arithmetic; 48 bits hold the 21-bit error shifted by up to 27, short of the largest gain shift of 31
  wire signed [47:0] err48  = {{27{phase_error_q[20]}}, phase_error_q};
  wire signed [47:0] lin    = err48 <<< g1;
  wire signed [47:0] ipath  = err48 <<< g2;
  wire signed [47:0] isum   = integ_q + ipath;
  wire               i_hi   = isum > $signed(`INT_MAX);
  wire               i_lo   = isum < $signed(`INT_MIN);
  wire signed [47:0] i_next = i_hi ? $signed(`INT_MAX) : i_lo ? $signed(`INT_MIN) : isum;
  wire signed [47:0] wsum   = (i_next + lin) >>> `FILT_SHIFT;
  wire               w_hi   = wsum > $signed(`WORD_MAX);
  wire               w_lo   = wsum < $signed(`WORD_MIN);
  wire [47:0]        wlim_hi = `WORD_MAX;
  wire [47:0]        wlim_lo = `WORD_MIN;
  wire [21:0]        w_next = w_hi ? wlim_hi[21:0] : w_lo ? wlim_lo[21:0] : wsum[21:0];
  // first-order sigma-delta: the filter word sets how often a step is taken
  wire [23:0]        sd_sum = sd_acc_q + {{2{filter_word_q[21]}}, filter_word_q};
  wire               sd_up  = !sd_sum[23] && (sd_sum >= `SD_TOP);
  wire               sd_dn  = sd_sum[23] && (sd_sum < (24'h00_0000 - `SD_TOP));

  ////////////////////////////////////////////////////////////////////////////////////////
  // loop datapath; loop_reset is a synchronous clear on top of the async rstn
  // every loop port is taken and launched on clk_sys only
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dsp_cnt_q       <= 16'h0000;
      first_q         <= 1'b1;
      update_strobe_q <= 1'b0;
      phase_error_q   <= 21'h00_0000;
      integ_q         <= 48'h0000_0000_0000;
      calc_q          <= 22'h00_0000;
      filter_word_q   <= 22'h00_0000;
      sd_acc_q        <= 24'h00_0000;
      phase_step_out  <= 5'h00;
      ovf_int_q       <= 1'b0;
      ovf_filt_q      <= 1'b0;
    end else if (clk_en) begin
      if (loop_reset) begin
        dsp_cnt_q       <= 16'h0000;
        first_q         <= 1'b1;
        update_strobe_q <= 1'b0;
        phase_error_q   <= 21'h00_0000;
        integ_q         <= 48'h0000_0000_0000;
        calc_q          <= 22'h00_0000;
        filter_word_q   <= 22'h00_0000;
        sd_acc_q        <= 24'h00_0000;
        phase_step_out  <= 5'h00;
        ovf_int_q       <= 1'b0;
        ovf_filt_q      <= 1'b0;
      end else begin
        dsp_cnt_q       <= dsp_tick ? 16'h0000 : dsp_cnt_q + 16'h0001;
        update_strobe_q <= dsp_tick;
        // detector runs regardless of hold and override
        if (dsp_tick) begin
          phase_error_q <= first_q ? 21'h00_0000 : pd_count;
          first_q       <= 1'b0;
        end
        // hold is the enable of integrator and computed word
        if (update_strobe_q && !hold) begin
          integ_q    <= i_next;
          calc_q     <= w_next;
          ovf_int_q  <= i_hi | i_lo;
          ovf_filt_q <= w_hi | w_lo;
        end
        // override replaces the word; release picks up the live value
        filter_word_q <= offset_sel ? offset_value : calc_q;
        // step word, two's complement, zero until the word moves off zero
        if (sd_up) begin
          sd_acc_q       <= sd_sum - `SD_WRAP;
          phase_step_out <= {1'b0, step};
        end else if (sd_dn) begin
          sd_acc_q       <= sd_sum + `SD_WRAP;
          phase_step_out <= 5'h00 - {1'b0, step};
        end else begin
          sd_acc_q       <= sd_sum;
          phase_step_out <= 5'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave: address and data latched separately, either order
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         aw_have_q;
  reg         w_have_q;
  wire [31:0] wmask;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      assign wmask[8*gi +: 8] = {8{w_strb_q[gi]}};
    end
  endgenerate
  wire [31:0] wmerge_gain = (gain_q & ~wmask) | (w_data_q & wmask);
  wire [31:0] wnew        = w_data_q & wmask;
  wire        do_write    = aw_have_q && w_have_q && !s_axi_bvalid;
  wire        aw_ok       = (aw_addr_q == `OFS_GAIN) || (aw_addr_q == `OFS_REF_DIV) ||
                            (aw_addr_q == `OFS_LOC_DIV) || (aw_addr_q == `OFS_DSP_RATE);
  reg  [31:0] rd_val;
  reg         rd_ok;

  // read decode; unmapped addresses answer slverr with zero data
  always @* begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr[7:0])
      `OFS_GAIN:     rd_val = gain_q;
      `OFS_REF_DIV:  rd_val = {16'h0000, ref_div_q};
      `OFS_LOC_DIV:  rd_val = {16'h0000, loc_div_q};
      `OFS_DSP_RATE: rd_val = {16'h0000, dsp_rate_q};
      `OFS_STATUS:   rd_val = {27'h000_0000, offset_sel, hold, ovf_filt_q, ovf_int_q, pd_ovf};
      `OFS_PH_ERR:   rd_val = {{11{phase_error_q[20]}}, phase_error_q};
      `OFS_FILT:     rd_val = {{10{filter_word_q[21]}}, filter_word_q};
      default:       rd_ok  = 1'b0;
    endcase
  end

  // bus handshakes and register writes
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      gain_q        <= `RST_GAIN;
      ref_div_q     <= `RST_REF_DIV;
      loc_div_q     <= `RST_LOC_DIV;
      dsp_rate_q    <= `RST_DSP_RATE;
    end else if (clk_en) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      if (s_axi_awvalid && !aw_have_q && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_addr_q     <= s_axi_awaddr[7:0];
        aw_have_q     <= 1'b1;
      end
      if (s_axi_wvalid && !w_have_q && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        w_have_q     <= 1'b1;
      end
      // write lands once both halves are held; divider changes may cost lock
      if (do_write) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_ok ? `RESP_OKAY : `RESP_SLVERR;
        case (aw_addr_q)
          `OFS_GAIN:     gain_q     <= wmerge_gain;
          `OFS_REF_DIV:  ref_div_q  <= (ref_div_q & ~wmask[15:0]) | wnew[15:0];
          `OFS_LOC_DIV:  loc_div_q  <= (loc_div_q & ~wmask[15:0]) | wnew[15:0];
          `OFS_DSP_RATE: dsp_rate_q <= (dsp_rate_q & ~wmask[15:0]) | wnew[15:0];
          default:       gain_q     <= gain_q;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // read: one outstanding, data registered with the valid
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // interp_dpll_control
`default_nettype wire

/* File: hw/dpll_defs.vh */
`ifndef DPLL_DEFS_VH
`define DPLL_DEFS_VH
// register byte offsets
`define OFS_GAIN      8'h00
`define OFS_REF_DIV   8'h04
`define OFS_LOC_DIV   8'h08
`define OFS_DSP_RATE  8'h0C
`define OFS_STATUS    8'h10
`define OFS_PH_ERR    8'h14
`define OFS_FILT      8'h18
// gain register fields
`define GAIN_G1_LSB   0
`define GAIN_G2_LSB   8
`define GAIN_STEP_LSB 16
// reset values
`define RST_GAIN      32'h0004_0808
`define RST_REF_DIV   16'h0000
`define RST_LOC_DIV   16'h0000
`define RST_DSP_RATE  16'h07FF
// status fields
`define ST_OVF_PD     0
`define ST_OVF_INT    1
`define ST_OVF_FILT   2
`define ST_HOLD       3
`define ST_OFFSET     4
// axi responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
// loop arithmetic
`define FILT_SHIFT    16
`define INT_MAX       48'h07FF_FFFF_FFFF
`define INT_MIN       48'hF800_0000_0000
`define WORD_MAX      48'h0000_001F_FFFF
`define WORD_MIN      48'hFFFF_FFE0_0000
`define SD_TOP        24'h10_0000
`define SD_WRAP       24'h20_0000
`define ERR_MAX       21'h0F_FFFF
`define ERR_MIN       21'h10_0001
`endif

/* File: hw/phase_compare.v */
`timescale 1ns/1ns
`default_nettype none
`include "dpll_defs.vh"
module phase_compare (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        clk_en,
  input  wire        clr,
  input  wire        ref_in,
  input  wire [15:0] ref_div,
  input  wire [15:0] loc_div,
  input  wire        sample,
  output reg  [20:0] count_q,
  output reg         ovf_q
);
  reg        ref_prev_q;
  reg [15:0] ref_cnt_q;
  reg [15:0] loc_cnt_q;
  wire       ref_edge = ref_in & ~ref_prev_q;
  // dividers count to div+1 so they divide by div+2
  wire       ref_tick = ref_edge && (ref_cnt_q == ref_div + 16'h0001);
  wire       loc_tick = (loc_cnt_q == loc_div + 16'h0001);
  wire [20:0] delta   = ref_tick && !loc_tick ? 21'h00_0001 :
                        loc_tick && !ref_tick ? 21'h1F_FFFF : 21'h00_0000;
  wire       at_max   = (count_q == `ERR_MAX);
  wire       at_min   = (count_q == `ERR_MIN);
  wire       sat_hit  = (delta == 21'h00_0001 && at_max) || (delta == 21'h1F_FFFF && at_min);

  ////////////////////////////////////////////////////////////////////////////////////////
  // up/down counter: reference ticks count up, local ticks count down
  // equal tick rates cancel, so a locked loop's error centres on zero
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ref_prev_q <= 1'b0;
      ref_cnt_q  <= 16'h0000;
      loc_cnt_q  <= 16'h0000;
      count_q    <= 21'h00_0000;
      ovf_q      <= 1'b0;
    end else if (clk_en) begin
      if (clr) begin
        ref_prev_q <= 1'b0;
        ref_cnt_q  <= 16'h0000;
        loc_cnt_q  <= 16'h0000;
        count_q    <= 21'h00_0000;
        ovf_q      <= 1'b0;
      end else begin
        ref_prev_q <= ref_in;
        if (ref_edge)
          ref_cnt_q <= ref_tick ? 16'h0000 : ref_cnt_q + 16'h0001;
        loc_cnt_q <= loc_tick ? 16'h0000 : loc_cnt_q + 16'h0001;
        // sampling restarts the window but keeps this cycle's tick, so none is lost
        if (sample)
          count_q <= delta;
        else if (!sat_hit)
          count_q <= count_q + delta;
        // saturation flag stands until the next window is sampled
        if (sat_hit)
          ovf_q <= 1'b1;
        else if (sample)
          ovf_q <= 1'b0;
      end
    end
  end
endmodule // phase_compare
`default_nettype wire

/* File: bench/dpll_ctrl_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module dpll_ctrl_sva (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        clk_en,
  input wire logic        loop_reset,
  input wire logic        hold,
  input wire logic        offset_sel,
  input wire logic [21:0] offset_value,
  input wire logic [4:0]  phase_step_out,
  input wire logic [20:0] phase_error_q,
  input wire logic [21:0] filter_word_q,
  input wire logic        update_strobe_q
);
  default clocking @(posedge clk_sys); endclocking
  // a frozen clock enable stalls every register, so checks pause with it
  default disable iff (!rstn || !clk_en);
  logic first_q;
  ////////////////////////////////////////////////////////////////////////
  // first detector sample since a loop clear is still pending
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) first_q <= 1'b1;
    else if (loop_reset) first_q <= 1'b1;
    else if (update_strobe_q) first_q <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // outputs are 21/22-bit signed, checked by port width
  a_reset_clear: assert property (loop_reset && !offset_sel |=>
    phase_error_q == 21'h00_0000 && filter_word_q == 22'h00_0000 && phase_step_out == 5'h00)
    else $error("loop outputs not cleared");
  a_first_error: assert property (update_strobe_q && first_q |->
    phase_error_q == 21'h00_0000) else $error("first error not zero");
  a_first_step: assert property ($fell(loop_reset) && !offset_sel |->
    (phase_step_out == 5'h00) [*2]) else $error("first step not zero");
  a_hold_freeze: assert property ((hold && !offset_sel && !loop_reset) [*3] |=>
    $stable(filter_word_q)) else $error("filter moved under hold");
  a_background_run: assert property ((hold || offset_sel) && update_strobe_q && !loop_reset
    |-> ##[1:1000] update_strobe_q) else $error("detector stopped");
  a_forced_word: assert property (offset_sel && !loop_reset |=>
    filter_word_q == $past(offset_value)) else $error("forced word not applied");
  a_resume_held: assert property ($fell(hold) && $past(hold, 2) && !$past(offset_sel)
    && !$past(offset_sel, 2) && !$past(loop_reset) |-> $stable(filter_word_q))
    else $error("filter jumped on hold release");
  a_strobe_pulse: assert property (update_strobe_q |=> !update_strobe_q)
    else $error("strobe longer than one cycle");
  a_error_on_strobe: assert property ($changed(phase_error_q) |->
    update_strobe_q || $past(loop_reset)) else $error("error changed off strobe");
endmodule // dpll_ctrl_sva
bind interp_dpll_control dpll_ctrl_sva dpll_ctrl_sva_inst (.clk_sys(clk_sys), .rstn(rstn),
  .clk_en(clk_en),
  .loop_reset(loop_reset), .hold(hold), .offset_sel(offset_sel), .offset_value(offset_value),
  .phase_step_out(phase_step_out), .phase_error_q(phase_error_q),
  .filter_word_q(filter_word_q), .update_strobe_q(update_strobe_q));
`default_nettype wire

/* File: bench/interp_step_sink.sv */
`timescale 1ns/1ns
`default_nettype none
module interp_step_sink (
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire logic [4:0]         interp_step_size_port,
  output var logic signed [31:0] phase_acc_q
);
  // straps recorded for the interpolator; nothing in this model reads them
  localparam logic       INTERP_PPM_CONTROL_ENABLE    = 1'b1;
  localparam logic       INTERP_PPM_SELECT            = 1'b1;
  localparam logic [2:0] INTERP_SYNC_FREQ_ATTR        = 3'h1;
  localparam logic       TX_BUFFER_BYPASS             = 1'b0;
  localparam logic [1:0] TX_PROGRAMMABLE_CLOCK_CHOICE = 2'h0;
  localparam logic [2:0] TX_OUTPUT_CLOCK_CHOICE       = 3'h5;
  // phase accumulates the signed step on the shared word clock
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) phase_acc_q <= 32'sh0;
    else phase_acc_q <= phase_acc_q + {{27{interp_step_size_port[4]}}, interp_step_size_port};
  end
endmodule // interp_step_sink
`default_nettype wire

/* File: bench/tb_interp_dpll_control.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_interp_dpll_control;
  logic        rstn, loop_reset, hold, offset_sel, clk_en;
  logic        clk_sys = 1'b0;
  logic        ref_in = 1'b0;
  logic [31:0] fz_err, fz_step, fz_filt;
  logic [21:0] offset_value, held;
  logic [20:0] e;
  logic [4:0]  phase_step_out;
  logic [20:0] phase_error_q;
  logic [21:0] filter_word_q;
  logic        update_strobe_q, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, rd, seed, ov;
  logic [31:0] mdl [4];
  logic [1:0]  bresp, rresp, rsp;
  int          err_total, n_compared;
  int          rc = 0;

  interp_dpll_control interp_dpll_control_inst (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
    .loop_reset(loop_reset), .ref_in(ref_in), .hold(hold), .offset_sel(offset_sel),
    .offset_value(offset_value), .phase_step_out(phase_step_out), .phase_error_q(phase_error_q),
    .filter_word_q(filter_word_q), .update_strobe_q(update_strobe_q), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  interp_step_sink interp_step_sink_inst (.clk_sys(clk_sys), .rstn(rstn),
    .interp_step_size_port(phase_step_out), .phase_acc_q());
  ////////////////////////////////////////////////////////////////////////
  always #2 clk_sys = ~clk_sys;
  // reference toggles every 9 cycles, driven on the edge like all loop inputs
  always @(posedge clk_sys) begin
    rc <= (rc == 8) ? 0 : rc + 1;
    if (rc == 8) ref_in <= ~ref_in;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // a wait that ran out is a mismatch and ends the run
  task tmo;
    err_total++;
    $display("CHECK FAILED handshake expected answer seen timeout");
    final_report();
  endtask
  // write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    bit got = 0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    if (!got) tmo();
  endtask
  // read: rready held until rvalid, data taken at that edge
  task automatic rchk(input logic [31:0] a, exp, input logic [1:0] re);
    bit got = 0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1;
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
      end
    end
    if (!got) tmo();
    chk("rdata", rd, exp);
    chk("rresp", {30'h0, rsp}, {30'h0, re});
  endtask
  // error is only meaningful in the strobe cycle
  task automatic strobe();
    bit got = 0;
    for (int n = 0; n < 100 && !got; n++) begin
      @(posedge clk_sys);
      if (update_strobe_q === 1'b1) begin
        got = 1;
        e = phase_error_q;
      end
    end
    if (!got) tmo();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, hold, offset_sel, awvalid, wvalid, bready, arvalid, rready} = 8'h0;
    {awaddr, wdata, araddr, offset_value, err_total, n_compared} = '0;
    clk_en = 1'b1;
    loop_reset = 1'b1; // held far longer than eight cycles
    seed = 32'h0000_13D9;
    mdl = '{32'h0004_0808, 32'h0, 32'h0, 32'h0000_07FF};
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) rchk(i * 4, mdl[i], 2'h0);
    rchk(32'h1C, 32'h0, 2'h2);
    wr(32'h10, rnd(), rsp);
    chk("ro bresp", {30'h0, rsp}, 32'h2);
    chk("step", {27'h0, phase_step_out}, 32'h0);
    $display("test register reset done");
    // random gains within range; upper lanes of 16-bit registers must be dropped
    mdl[0] = rnd() % 19 | (rnd() % 21) << 8 | (rnd() % 15 + 1) << 16;
    mdl[1] = rnd() & 32'h3;
    mdl[2] = rnd() & 32'h3;
    mdl[3] = 32'hF;
    for (int i = 0; i < 4; i++) begin
      wr(i * 4, mdl[i] | (i > 0 ? 32'hABCD_0000 : 32'h0), rsp);
      rchk(i * 4, mdl[i], 2'h0);
    end
    loop_reset <= 1'b0; // analog front reset assumed complete here
    @(posedge clk_sys);
    chk("first step", {27'h0, phase_step_out}, 32'h0);
    strobe();
    chk("first error", {11'h0, e}, 32'h0);
    $display("test loop start done");
    hold <= 1'b1;
    repeat (4) @(posedge clk_sys);
    held = filter_word_q;
    strobe(); // detector keeps running under hold
    chk("held", {10'h0, filter_word_q}, {10'h0, held});
    ov = rnd();
    offset_value <= ov[21:0];
    offset_sel <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("forced", {10'h0, filter_word_q}, {10'h0, ov[21:0]});
    strobe();
    offset_sel <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("unforced", {10'h0, filter_word_q}, {10'h0, held});
    hold <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("resumed", {10'h0, filter_word_q}, {10'h0, held});
    $display("test hold and force done");
    // clock enable low must freeze the loop across a strobe period
    clk_en <= 1'b0;
    @(posedge clk_sys);
    fz_err = {11'h0, phase_error_q};
    fz_step = {27'h0, phase_step_out};
    fz_filt = {10'h0, filter_word_q};
    repeat (20) @(posedge clk_sys);
    chk("frozen err", {11'h0, phase_error_q}, fz_err);
    chk("frozen step", {27'h0, phase_step_out}, fz_step);
    chk("frozen filt", {10'h0, filter_word_q}, fz_filt);
    chk("frozen strobe", {31'h0, update_strobe_q}, 32'h0);
    clk_en <= 1'b1;
    $display("test clock enable done");
    repeat (20) @(posedge clk_sys);
    loop_reset <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("cleared", {10'h0, filter_word_q}, 32'h0);
    chk("cleared err", {11'h0, phase_error_q}, 32'h0);
    loop_reset <= 1'b0;
    strobe();
    chk("error again", {11'h0, e}, 32'h0);
    $display("test loop clear done");
    final_report();
  end
endmodule // tb_interp_dpll_control
`default_nettype wire
